// ### rtl/tof_spi_cfg.svh
// command codes, response words and timing counts of the sensor serial link
`ifndef TOF_SPI_CFG_SVH
`define TOF_SPI_CFG_SVH

`define FRAME_BITS      5'h10
`define CMD_IDLE_POLL   3'h0
`define CMD_READ        3'h1
`define CMD_WRITE       3'h2
`define CMD_ABORT       3'h3
`define CMD_PAGE        3'h4
`define CMD_SOFT_RESET  3'h6

`define RID_READ_DONE   3'h1
`define RID_WRITE_DONE  3'h2
`define RID_PAGE        3'h4

`define RSP_IDLE        16'h0000
`define RSP_RD_BUSY     16'h7333
`define RSP_WR_BUSY     16'hCCCC
`define RSP_ABORT_CMD        16'hE38E
`define RSP_ERROR       16'hF5FF

`define PAGE_RESET      3'h0
`define T_SYS_NS        5
`define T_SCLK_MIN_NS   119
`define SCLK_HALF_CYC   ((`T_SCLK_MIN_NS + 2 * `T_SYS_NS - 1) / (2 * `T_SYS_NS))
`define RESP_WAIT_CYC   8
`define FRAME_GAP_CYC   24

`endif

// ### rtl/tof_spi_pkg.sv
// types shared by both ends of the sensor serial link
package tof_spi_pkg;

	typedef enum logic [0:0] {
		DEV_IDLE = 1'b0,
		DEV_WAIT = 1'b1
	} dev_state_type;

	typedef enum logic [2:0] {
		HST_IDLE = 3'b000,
		HST_LEAD = 3'b001,
		HST_HIGH = 3'b010,
		HST_LOW  = 3'b011,
		HST_TAIL = 3'b100,
		HST_GAP  = 3'b101
	} host_state_type;

	typedef struct packed {
		dev_state_type state;
		logic [2:0]    frm_sync;
		logic [2:0]    page;
		logic          busy;
		logic          done;
		logic [15:0]   done_word;
		logic [15:0]   resp;
		logic          op_valid;
		logic          op_write;
		logic [7:0]    op_addr;
		logic [7:0]    op_wdata;
		logic [3:0]    wait_cnt;
		logic          soft_reset;
	} dev_sys_type;

	typedef struct packed {
		host_state_type state;
		logic [7:0]     cnt;
		logic [4:0]     bits;
		logic [15:0]    tx;
		logic [15:0]    rx;
		logic           sclk;
		logic           ss_n;
		logic           mosi;
		logic [1:0]     miso_sync;
		logic           rsp_valid;
		logic [15:0]    rsp_word;
	} host_type;

endpackage

// ### rtl/tof_spi_if.sv
// serial link wires between the sensor end and the controlling master
`timescale 1ns/1ps
interface tof_spi_if;
	logic sclk;
	logic slave_select_n;
	logic mosi;
	logic miso;

	modport dev
	(
		input  sclk,
		input  slave_select_n,
		input  mosi,
		output miso
	);

	modport host
	(
		output sclk,
		output slave_select_n,
		output mosi,
		input  miso
	);
endinterface

// ### rtl/tof_spi_device.sv
// sensor end of the serial link: frame capture on the link clock, command engine on clk_sys
`timescale 1ns/1ps
`include "tof_spi_cfg.svh"

// Operation
// [R1] slave only, fixed 16-bit frames
// [R2] shift out previous frame's result while receiving
// [R3] MISO always driven, never released
// [R4] most significant bit first both ways
// [R5] master holds select low whole frame
// [R6] command: code, location, payload fields
// [R7] response: code, location, data fields
// [R8] sample on rise, change after fall
// [R9] first bit valid before first clock edge
// [R10] select toggles between frames, resynchronising
// [R11] select rise ends and starts command
// [R12] answer next frame, first gives idle
// [R13] master closes with idle poll frame
// [R14] commands during busy report are dropped; the code still executes an abort command while busy
// [R15] master resends dropped commands
// [R16] location is page joined with address
// [R17] command code table, others reserved
// [R18] page pointer: three bits, default zero
// [R19] busy read/write gives fixed not-done word
// [R20] wrong length frame gives error word
// [R21] released select clears bit counter asynchronously
module tof_spi_device
(
	// link
	tof_spi_if.dev     link,
	// system clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// register access towards the sensor core
	output logic             op_valid,
	output logic             op_write,
	output logic [7:0]       op_addr,
	output logic [7:0]       op_wdata,
	input  wire logic        op_ready,
	input  wire logic [7:0]  op_rdata,
	// status
	output logic [2:0]       page_sel,
	output logic             soft_reset
);

	// ------------------------------------------------------------
	// link domain
	// ------------------------------------------------------------
	logic [4:0]  bit_cnt_r;
	logic [15:0] shift_in_r;
	logic [3:0]  out_idx_r;
	logic [15:0] frm_word_r;
	logic        frm_good_r;
	logic        frm_tgl_r;
	logic [15:0] resp_shadow_r;
	tof_spi_pkg::dev_sys_type sys_r;
	tof_spi_pkg::dev_sys_type sys_nxt;

	// counter cleared while deselected so a cut frame never lines up later
	always_ff @(posedge link.sclk or posedge link.slave_select_n)
	begin
		if (link.slave_select_n)
			bit_cnt_r <= 5'h00; // [R21] [R10]
		else if (bit_cnt_r != 5'h1F)
			bit_cnt_r <= bit_cnt_r + 5'h01;
	end

	always_ff @(posedge link.sclk)
	begin
		shift_in_r <= {shift_in_r[14:0], link.mosi}; // [R8] [R4]
	end

	always_ff @(negedge link.sclk or posedge link.slave_select_n)
	begin
		if (link.slave_select_n)
			out_idx_r <= 4'h0;
		else if (out_idx_r != 4'hF)
			out_idx_r <= out_idx_r + 4'h1; // [R8] [R9]
	end

	// frame is judged at select rise; only a whole 16-edge frame executes
	always_ff @(posedge link.slave_select_n or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			frm_word_r <= 16'h0000;
			frm_good_r <= 1'b0;
			frm_tgl_r  <= 1'b0;
		end
		else
		begin
			frm_word_r <= shift_in_r; // [R11] [R6]
			frm_good_r <= (bit_cnt_r == `FRAME_BITS); // [R1] [R20]
			frm_tgl_r  <= ~frm_tgl_r;
		end
	end

	// engine publishes its word a few cycles after select rise, so it is still at select fall
	always_ff @(negedge link.slave_select_n or posedge sys_rst)
	begin
		if (sys_rst)
			resp_shadow_r <= `RSP_IDLE;
		else
			resp_shadow_r <= sys_r.resp; // [R2] [R12]
	end

	assign link.miso = resp_shadow_r[4'hF - out_idx_r]; // [R3] [R4] [R7] [R9]

	// ------------------------------------------------------------
	// system domain
	// ------------------------------------------------------------
	logic        frame_end;
	logic        ready_now;
	logic [2:0]  code;
	logic [4:0]  loc;
	logic [7:0]  pay;

	function automatic logic [15:0] done_word(input logic wr, input logic [4:0] a,
		input logic [7:0] d);
		done_word = {(wr ? `RID_WRITE_DONE : `RID_READ_DONE), a, d}; // [R7]
	endfunction

	assign frame_end = sys_r.frm_sync[2] ^ sys_r.frm_sync[1];
	assign ready_now = sys_r.op_valid & op_ready;
	assign code      = frm_word_r[15:13]; // [R6]
	assign loc       = frm_word_r[12:8];
	assign pay       = frm_word_r[7:0];

	always_comb
	begin
		sys_nxt            = sys_r;
		sys_nxt.frm_sync   = {sys_r.frm_sync[1:0], frm_tgl_r};
		sys_nxt.soft_reset = 1'b0;
		if (sys_r.wait_cnt != 4'h0)
			sys_nxt.wait_cnt = sys_r.wait_cnt - 4'h1;
		// completion while busy is remembered for the next frame
		if (ready_now)
		begin
			sys_nxt.op_valid  = 1'b0;
			sys_nxt.done      = 1'b1;
			sys_nxt.done_word = done_word(sys_r.op_write, sys_r.op_addr[4:0],
				sys_r.op_write ? sys_r.op_wdata : op_rdata);
		end
		case (sys_r.state)
			tof_spi_pkg::DEV_WAIT:
			begin
				if (ready_now)
				begin
					sys_nxt.resp  = sys_nxt.done_word; // [R12]
					sys_nxt.done  = 1'b0;
					sys_nxt.state = tof_spi_pkg::DEV_IDLE;
				end
				else if (sys_r.wait_cnt == 4'h0)
				begin
					sys_nxt.resp  = sys_r.op_write ? `RSP_WR_BUSY : `RSP_RD_BUSY; // [R19]
					sys_nxt.busy  = 1'b1;
					sys_nxt.state = tof_spi_pkg::DEV_IDLE;
				end
			end
			default:
			begin
				if (frame_end)
				begin
					if (!frm_good_r)
						sys_nxt.resp = `RSP_ERROR; // [R20]
					else if (code == `CMD_ABORT)
					begin
						sys_nxt.op_valid = 1'b0;
						sys_nxt.busy     = 1'b0;
						sys_nxt.done     = 1'b0;
						sys_nxt.resp     = `RSP_ABORT_CMD; // [R17]
					end
					else if (sys_r.busy)
					begin
						// the command of this frame is dropped; only progress is reported
						if (sys_nxt.done)
						begin
							sys_nxt.resp = sys_nxt.done_word; // [R14] [R19]
							sys_nxt.busy = 1'b0;
							sys_nxt.done = 1'b0;
						end
					end
					else if (code == `CMD_READ || code == `CMD_WRITE)
					begin
						sys_nxt.op_valid = 1'b1;
						sys_nxt.op_write = (code == `CMD_WRITE);
						sys_nxt.op_addr  = {sys_r.page, loc}; // [R16]
						sys_nxt.op_wdata = pay;
						sys_nxt.done     = 1'b0;
						sys_nxt.wait_cnt = 4'(`RESP_WAIT_CYC);
						sys_nxt.state    = tof_spi_pkg::DEV_WAIT;
					end
					else if (code == `CMD_PAGE)
					begin
						sys_nxt.page = loc[2:0]; // [R18]
						sys_nxt.resp = {`RID_PAGE, 2'b00, loc[2:0], 8'h00};
					end
					else if (code == `CMD_SOFT_RESET)
					begin
						sys_nxt.page       = `PAGE_RESET;
						sys_nxt.soft_reset = 1'b1;
						sys_nxt.resp       = `RSP_IDLE;
					end
					else if (code == `CMD_IDLE_POLL)
						sys_nxt.resp = `RSP_IDLE; // [R12] [R13]
					else
						sys_nxt.resp = `RSP_ERROR; // [R17]
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			sys_r          <= '0;
			sys_r.state    <= tof_spi_pkg::DEV_IDLE;
			sys_r.page     <= `PAGE_RESET; // [R18]
			sys_r.resp     <= `RSP_IDLE;
		end
		else
			sys_r <= sys_nxt;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign op_valid   = sys_r.op_valid;
	assign op_write   = sys_r.op_write;
	assign op_addr    = sys_r.op_addr;
	assign op_wdata   = sys_r.op_wdata;
	assign page_sel   = sys_r.page;
	assign soft_reset = sys_r.soft_reset;

endmodule

// ### rtl/tof_spi_host.sv
// master end of the serial link: makes the link clock by division and runs one frame per command
`timescale 1ns/1ps
`include "tof_spi_cfg.svh"

module tof_spi_host
#(
	parameter logic [7:0] HALF_CYC = 8'(`SCLK_HALF_CYC),
	parameter logic [7:0] GAP_CYC  = 8'(`FRAME_GAP_CYC)
)
(
	// system clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// command and response
	input  wire logic        cmd_valid,
	input  wire logic [15:0] cmd_word,
	output logic             cmd_ready,
	output logic             rsp_valid,
	output logic [15:0]      rsp_word,
	// link
	tof_spi_if.host    link
);

	tof_spi_pkg::host_type h_r;
	tof_spi_pkg::host_type h_nxt;

	always_comb
	begin
		h_nxt           = h_r;
		h_nxt.miso_sync = {h_r.miso_sync[0], link.miso};
		h_nxt.rsp_valid = 1'b0;
		if (h_r.cnt != 8'h00)
			h_nxt.cnt = h_r.cnt - 8'h01;
		case (h_r.state)
			tof_spi_pkg::HST_IDLE:
			begin
				if (cmd_valid)
				begin
					h_nxt.tx    = cmd_word;
					h_nxt.ss_n  = 1'b0; // [R5]
					h_nxt.mosi  = cmd_word[15]; // [R4]
					h_nxt.bits  = 5'h00;
					h_nxt.cnt   = HALF_CYC;
					h_nxt.state = tof_spi_pkg::HST_LEAD;
				end
			end
			tof_spi_pkg::HST_LEAD, tof_spi_pkg::HST_LOW:
			begin
				if (h_r.cnt == 8'h00)
				begin
					h_nxt.sclk  = 1'b1;
					h_nxt.rx    = {h_r.rx[14:0], h_r.miso_sync[1]}; // [R8]
					h_nxt.bits  = h_r.bits + 5'h01;
					h_nxt.cnt   = HALF_CYC;
					h_nxt.state = tof_spi_pkg::HST_HIGH;
				end
			end
			tof_spi_pkg::HST_HIGH:
			begin
				if (h_r.cnt == 8'h00)
				begin
					h_nxt.sclk = 1'b0;
					h_nxt.cnt  = HALF_CYC;
					if (h_r.bits == `FRAME_BITS)
						h_nxt.state = tof_spi_pkg::HST_TAIL; // [R8]
					else
					begin
						h_nxt.tx    = {h_r.tx[14:0], 1'b0};
						h_nxt.mosi  = h_r.tx[14];
						h_nxt.state = tof_spi_pkg::HST_LOW;
					end
				end
			end
			tof_spi_pkg::HST_TAIL:
			begin
				if (h_r.cnt == 8'h00)
				begin
					h_nxt.ss_n      = 1'b1; // [R10]
					h_nxt.rsp_valid = 1'b1;
					h_nxt.rsp_word  = h_r.rx; // [R2] [R15]
					h_nxt.cnt       = GAP_CYC;
					h_nxt.state     = tof_spi_pkg::HST_GAP;
				end
			end
			default:
			begin
				// gap lets the far end publish its answer before the next select fall
				if (h_r.cnt == 8'h00)
					h_nxt.state = tof_spi_pkg::HST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			h_r       <= '0;
			h_r.state <= tof_spi_pkg::HST_IDLE;
			h_r.ss_n  <= 1'b1;
		end
		else
			h_r <= h_nxt;
	end

	assign cmd_ready           = (h_r.state == tof_spi_pkg::HST_IDLE);
	assign rsp_valid           = h_r.rsp_valid;
	assign rsp_word            = h_r.rsp_word;
	assign link.sclk           = h_r.sclk;
	assign link.slave_select_n = h_r.ss_n;
	assign link.mosi           = h_r.mosi;

endmodule

// ### verification/tof_spi_chk.sv
// concurrent checks on the wires of the sensor serial link
`timescale 1ns/1ps
`include "tof_spi_cfg.svh"

module tof_spi_chk
(
	// system clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// link
	input wire logic sclk,
	input wire logic slave_select_n,
	input wire logic mosi,
	input wire logic miso
);
	// ----------------------------------------
	// frame capture
	// ----------------------------------------
	logic        sclk_q;
	logic        ss_q;
	logic [4:0]  rises;
	logic [15:0] rx_mosi;
	logic [15:0] rx_miso;
	logic [15:0] last_cmd;
	logic [15:0] last_rsp;

	function automatic logic busy(input logic [15:0] w);
		busy = (w == `RSP_RD_BUSY) || (w == `RSP_WR_BUSY);
	endfunction

	function automatic logic legal(input logic [15:0] w);
		case (w[15:13])
			3'h0: legal = (w == `RSP_IDLE);
			3'h3: legal = (w == `RSP_RD_BUSY);
			3'h4: legal = (w[12:11] == 2'h0) && (w[7:0] == 8'h00);
			3'h5: legal = 1'b0;
			3'h6: legal = (w == `RSP_WR_BUSY);
			3'h7: legal = (w == `RSP_ABORT_CMD) || (w == `RSP_ERROR);
			default: legal = 1'b1;
		endcase
	endfunction

	// sclk comes from clk_sys logic, so sampling it on clk_sys sees every edge
	always_ff @(posedge clk_sys)
	begin
		sclk_q <= sclk;
		ss_q <= slave_select_n;
		if (sys_rst || (ss_q && !slave_select_n))
			rises <= 5'h00;
		else if (sclk && !sclk_q)
			rises <= rises + 5'h01;
		if (sclk && !sclk_q)
		begin
			rx_mosi <= {rx_mosi[14:0], mosi};
			rx_miso <= {rx_miso[14:0], miso};
		end
		if (sys_rst)
		begin
			last_cmd <= 16'h0000;
			last_rsp <= 16'h0000;
		end
		else if (slave_select_n && !ss_q)
		begin
			last_cmd <= rx_mosi;
			last_rsp <= rx_miso;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	sequence frame_end;
		$rose(slave_select_n);
	endsequence

	sclk_idle_a: assert property (slave_select_n |-> !sclk)
		else $error("link clock runs while deselected");
	mosi_hold_a: assert property (sclk && !slave_select_n |-> $stable(mosi))
		else $error("command bit moved while clock high");
	miso_edge_a: assert property ($changed(miso) && !slave_select_n && !$past(slave_select_n)
		|-> !sclk && ($past(sclk) || $past(sclk, 2))) else $error("response bit moved off a fall");
	frame_len_a: assert property (frame_end |-> rises == 5'h10 && !sclk)
		else $error("frame did not hold sixteen rises");
	lead_time_a: assert property ($fell(slave_select_n) |-> !sclk [*2])
		else $error("clock rose too soon after select");
	frame_gap_a: assert property (frame_end |-> slave_select_n [*8])
		else $error("select gap too short");
	resp_form_a: assert property (frame_end |-> legal(rx_miso))
		else $error("response word not of a legal form");
	idle_ans_a: assert property ((frame_end ##0
		(last_cmd[15:13] == 3'h0 && last_rsp == 16'h0000)) |-> rx_miso == `RSP_IDLE)
		else $error("idle poll not answered idle");
	page_ans_a: assert property ((frame_end ##0 (last_cmd[15:13] == 3'h4 && !busy(last_rsp)))
		|-> rx_miso == {3'h4, 2'h0, last_cmd[10:8], 8'h00}) else $error("page answer wrong");
	abort_ans_a: assert property ((frame_end ##0 last_cmd[15:13] == 3'h3)
		|-> rx_miso == `RSP_ABORT_CMD) else $error("abort answer wrong");
	read_ans_a: assert property ((frame_end ##0 (last_cmd[15:13] == 3'h1 && !busy(last_rsp)))
		|-> (rx_miso[15:8] == {3'h1, last_cmd[12:8]}) || rx_miso == `RSP_RD_BUSY)
		else $error("read answer wrong");
endmodule

// ### verification/tof_sensor_spi_slave_bench.sv
// self-checking bench: host and sensor ends joined over the link
`timescale 1ns/1ps
`include "tof_spi_cfg.svh"
`define CHECK(got, exp) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) \
		begin \
			n_fail++; \
			$display("wrong value t=%0t got %h exp %h", $time, got, exp); \
		end \
	end

module tof_sensor_spi_slave_bench;
	logic        clk_sys;
	logic        sys_rst;
	logic        cmd_valid;
	logic [15:0] cmd_word;
	logic        cmd_ready;
	logic        rsp_valid;
	logic [15:0] rsp_word;
	logic        op_valid;
	logic        op_write;
	logic [7:0]  op_addr;
	logic [7:0]  op_wdata;
	logic        op_ready;
	logic [7:0]  op_rdata;
	logic [2:0]  page_sel;
	logic        soft_reset;
	logic        sr_seen = 1'b0;
	logic [7:0]  seen_addr;
	logic [8:0]  seen_wr;
	logic [15:0] pend;
	logic [15:0] rx;
	logic [2:0]  pg;
	logic [15:0] c;
	logic [2:0]  codes [8] = '{3'h4, 3'h1, 3'h2, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};
	int          n_fail;
	int          samples_checked;
	int          op_wait;
	int          op_delay;
	int          seed;
	tof_spi_if   link ();
	tof_spi_if   link2 ();

	tof_spi_host #(.HALF_CYC(8'h04), .GAP_CYC(8'h10)) u_tof_spi_host
	(.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_word(rsp_word), .link(link));
	tof_spi_device u_tof_spi_device
	(.link(link), .clk_sys(clk_sys), .sys_rst(sys_rst), .op_valid(op_valid), .op_write(op_write),
		.op_addr(op_addr), .op_wdata(op_wdata), .op_ready(op_ready), .op_rdata(op_rdata),
		.page_sel(page_sel), .soft_reset(soft_reset));
	// second sensor end, driven by hand so frames of wrong length can be sent
	tof_spi_device u_tof_spi_device_fault
	(.link(link2), .clk_sys(clk_sys), .sys_rst(sys_rst), .op_valid(), .op_write(), .op_addr(),
		.op_wdata(), .op_ready(1'b1), .op_rdata(8'h00), .page_sel(), .soft_reset());
	tof_spi_chk u_tof_spi_chk
	(.clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(link.sclk), .slave_select_n(link.slave_select_n),
		.mosi(link.mosi), .miso(link.miso));

	assign op_rdata = op_addr ^ 8'hA5;

	function automatic logic [15:0] exp_of(input logic [15:0] w);
		case (w[15:13])
			`CMD_IDLE_POLL, `CMD_SOFT_RESET: exp_of = `RSP_IDLE;
			`CMD_READ: exp_of = {`RID_READ_DONE, w[12:8], {pg, w[12:8]} ^ 8'hA5};
			`CMD_WRITE: exp_of = {`RID_WRITE_DONE, w[12:0]};
			`CMD_ABORT: exp_of = `RSP_ABORT_CMD;
			`CMD_PAGE: exp_of = {`RID_PAGE, 2'h0, w[10:8], 8'h00};
			default: exp_of = `RSP_ERROR;
		endcase
	endfunction

	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// one frame; the answer that comes back belongs to the previous command
	task automatic send(input logic [15:0] w);
		int t;
		t = 0;
		while (cmd_ready !== 1'b1 && t < 2000)
		begin
			@(negedge clk_sys);
			t++;
		end
		cmd_valid = 1'b1;
		cmd_word = w;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		t = 0;
		while (rsp_valid !== 1'b1 && t < 2000)
		begin
			@(negedge clk_sys);
			t++;
		end
		if (t >= 2000)
			n_fail++;
		`CHECK(rsp_word, pend)
		pend = exp_of(w);
		if (w[15:13] == `CMD_PAGE)
			pg = w[10:8];
		else if (w[15:13] == `CMD_SOFT_RESET)
			pg = `PAGE_RESET;
	endtask

	task automatic bang(input int n, input logic [15:0] w);
		rx = 16'h0000;
		link2.slave_select_n = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			link2.mosi = w[15 - i];
			#62.5 link2.sclk = 1'b1;
			rx = {rx[14:0], link2.miso};
			#62.5 link2.sclk = 1'b0;
		end
		#62.5 link2.slave_select_n = 1'b1;
		link2.mosi = ~link2.mosi;
		#500;
	endtask

	always @(negedge clk_sys)
	begin
		op_ready <= 1'b0;
		if (soft_reset === 1'b1)
			sr_seen <= 1'b1;
		if (op_valid === 1'b1 && op_ready !== 1'b1)
		begin
			op_wait <= op_wait + 1;
			if (op_wait >= op_delay)
			begin
				op_ready <= 1'b1;
				op_wait <= 0;
				seen_addr <= op_addr;
				seen_wr <= {op_write, op_wdata};
			end
		end
	end

	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	initial
	begin
		#300000;
		n_fail++;
		summarize;
	end

	initial
	begin
		seed = 32'h3036691B;
		{sys_rst, cmd_valid, cmd_word, op_delay} = '0;
		sys_rst = 1'b1;
		{pend, pg} = '0;
		link2.sclk = 1'b0;
		link2.slave_select_n = 1'b1;
		link2.mosi = 1'b0;
		repeat (8) @(negedge clk_sys);
		sys_rst = 1'b0;
		send(16'h0000);
		send(16'h8700);
		send(16'h5F3C);
		send(16'h0000);
		`CHECK(page_sel, 3'h7)
		`CHECK(seen_addr, 8'hFF)
		`CHECK(seen_wr, 9'h13C)
		for (int r = 0; r < 3; r++)
			for (int k = 0; k < 8; k++)
			begin
				op_delay = int'($unsigned($random(seed)) % 3);
				send({codes[k], 13'($random(seed))});
			end
		send(16'h8200);
		`CHECK(sr_seen, 1'b1)
		// a slow core access: the next command is dropped while busy
		op_delay = 40;
		for (int k = 0; k < 2; k++)
		begin
			c = k ? 16'h2B00 : 16'h4A11;
			send(c);
			rx = pend;
			pend = c[14] ? `RSP_WR_BUSY : `RSP_RD_BUSY;
			send(16'h2300);
			pend = rx;
			send(16'h0000);
		end
		op_delay = 0;
		send(16'h0000);
		#3.1;
		bang(12, 16'h4A11);
		bang(16, 16'h0000);
		`CHECK(rx, `RSP_ERROR)
		bang(16, 16'h0000);
		`CHECK(rx, `RSP_IDLE)
		summarize;
	end
endmodule
